// ---- core/flash_cfg_pkg.sv ----
/*
  Package for the Flash wait / host gate / clock speed configuration block.
  Assumes a single 10 MHz clock domain and an AXI4-Lite register bus.
*/
package flash_cfg_pkg;
  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [3:0] OFS_FLASH_WAIT  = 4'h0;
  localparam logic [3:0] OFS_CLOCK_CFG   = 4'h4;
  localparam logic [3:0] OFS_STATUS      = 4'h8;
  localparam logic [3:0] OFS_ACCESS_REQ  = 4'hC;
  // ==========================================================================
  // Field layout and reset values
  // ==========================================================================
  localparam int         HOST_ALLOW_BIT  = 3;
  localparam int         FAST_CLK_BIT    = 7;
  localparam logic [1:0] FLASH_WAIT_RST  = 2'h3;
  localparam logic       HOST_ALLOW_RST  = 1'b1;
  localparam logic       FAST_CLK_RST    = 1'b1;
  // ==========================================================================
  // Timing, bus response codes and access states
  // ==========================================================================
  localparam int         CLKS_PER_WAIT   = 2;
  localparam logic [7:0] HOST_WAIT_FAST  = 8'hC0;
  localparam logic [7:0] HOST_WAIT_SLOW  = 8'h60;
  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;
  typedef enum logic [1:0]
  {
    ACC_IDLE = 2'b00,
    ACC_WAIT = 2'b01,
    ACC_DONE = 2'b10
  } acc_state_t;
endpackage : flash_cfg_pkg

// ---- core/flash_wait_timer.sv ----
/*
  Flash access wait-state sequencer: stretches one granted access by the
  programmed number of wait states, two clocks each.
  Samples acc_req only while idle, so a one-clock request pulse suffices.
*/
`timescale 1ns/1ps
`default_nettype none
module flash_wait_timer
  import flash_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Access request
  input  wire logic       acc_req,
  input  wire logic [1:0] wait_count,
  output logic            acc_done,
  output logic            acc_busy
);
  acc_state_t state_ff;
  acc_state_t nxt_state;
  logic [2:0] cnt_ff;
  logic [2:0] nxt_cnt;
  wire  [2:0] load_cnt;
  // Each wait state is two clocks.
  assign load_cnt = {wait_count, 1'b0}; // R3

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      ACC_IDLE:
        if (acc_req)
        begin
          nxt_cnt   = load_cnt; // R2
          nxt_state = (load_cnt == 3'h0) ? ACC_DONE : ACC_WAIT;
        end
      ACC_WAIT:
      begin
        nxt_cnt = cnt_ff - 3'h1;
        if (cnt_ff == 3'h1)
          nxt_state = ACC_DONE;
      end
      ACC_DONE:
        nxt_state = ACC_IDLE;
      default:
        nxt_state = ACC_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_ff <= ACC_IDLE;
      cnt_ff   <= 3'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  assign acc_done = (state_ff == ACC_DONE);
  assign acc_busy = (state_ff != ACC_IDLE);

  a_wait_length: assert property (@(posedge aclk) disable iff (!aresetn) // R3
    (state_ff == ACC_IDLE && acc_req && wait_count == 2'h1)
      |=> (state_ff == ACC_WAIT) [*2] ##1 (state_ff == ACC_DONE))
    else $error("one wait state did not last two clocks");
  a_zero_wait: assert property (@(posedge aclk) disable iff (!aresetn) // R2
    (state_ff == ACC_IDLE && acc_req && wait_count == 2'h0)
      |=> state_ff == ACC_DONE)
    else $error("zero wait access was stretched");
endmodule : flash_wait_timer
`default_nettype wire

// ---- core/flash_wait_host_gate_clock_cfg.sv ----
/*
  Flash wait / host gate / fast clock configuration with AXI4-Lite slave.
  Assumes one 10 MHz clock; host and core access requests come from logic
  on the same clock and hold until their done pulse.
*/
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Function
// R1 - A host memory access passes only while the host allow bit is one.
// R2 - The two-bit Flash wait code selects 0 to 3 wait states, reset 3.
// R3 - Every added Flash wait state lasts two main clock periods.
// R4 - The same wait count applies to core and to host Flash accesses.
// R5 - Firmware sets the wait count no lower than the core's own waits.
// R6 - Software writes zero to reserved bits, whose reads are undefined.
// R7 - With fast clock select set the transceiver clock is divided by two.
// R8 - The host wait limit is 192 clocks when fast, 96 when slow.
// R9 - That limit keeps the host WAIT assertion within the card limit.
// R10 - Firmware sets fast clock select for a main clock above 20 MHz.
// R11 - Firmware should clear fast clock select at 20 MHz or slower.
// R12 - Fast clock select resets to one and also reaches the rate logic.
module flash_wait_host_gate_clock_cfg
  import flash_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address and data
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Flash accesses from core and host
  input  wire logic        core_flash_req,
  input  wire logic        host_flash_req,
  output logic             core_flash_done,
  output logic             host_flash_done,
  output logic             host_flash_blocked,
  // Host bus wait and transceiver clock enable
  output logic             host_wait_ff,
  output logic             attach_clk_en_ff,
  output logic             fast_clock_select_ff
);
  // ==========================================================================
  // Configuration registers
  // ==========================================================================
  logic [1:0] flash_wait_count_ff;
  logic       host_mem_access_allow_ff;
  logic [7:0] host_wait_limit_counter_ff;
  logic       host_timeout_ff;
  logic       div_ff;
  logic       owner_host_ff;
  logic       core_done_ff;
  logic       host_done_ff;
  logic       blocked_ff;

  wire        wr_go;
  wire        wr_flash;
  wire        wr_clock;
  wire        wr_hit;
  wire        acc_done;
  wire        acc_busy;
  wire        grant_host;
  wire        grant_core;
  wire        acc_req;
  wire        done_hold;
  wire        host_active;
  wire [7:0]  wait_limit;
  wire [31:0] rd_mux;
  wire        rd_hit;

  assign wr_go    = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign wr_flash = wr_go && s_axi_awaddr == OFS_FLASH_WAIT && s_axi_wstrb[0];
  assign wr_clock = wr_go && s_axi_awaddr == OFS_CLOCK_CFG && s_axi_wstrb[0];
  assign wr_hit   = s_axi_awaddr == OFS_FLASH_WAIT
                 || s_axi_awaddr == OFS_CLOCK_CFG;
  // Reserved bits are not stored and read back as zero.
  assign rd_hit   = s_axi_araddr == OFS_FLASH_WAIT
                 || s_axi_araddr == OFS_CLOCK_CFG
                 || s_axi_araddr == OFS_STATUS;
  assign rd_mux   = (s_axi_araddr == OFS_FLASH_WAIT) ?
                      {28'h0, host_mem_access_allow_ff, 1'b0,
                       flash_wait_count_ff} : // R6
                    (s_axi_araddr == OFS_CLOCK_CFG) ?
                      {24'h0, fast_clock_select_ff, 7'h0} :
                    (s_axi_araddr == OFS_STATUS) ?
                      {20'h0, host_timeout_ff, host_wait_ff, acc_busy,
                       owner_host_ff, host_wait_limit_counter_ff} :
                      32'h0;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flash_wait_count_ff      <= FLASH_WAIT_RST; // R2
      host_mem_access_allow_ff <= HOST_ALLOW_RST;
      fast_clock_select_ff     <= FAST_CLK_RST; // R12
    end
    else
    begin
      if (wr_flash)
      begin
        flash_wait_count_ff      <= s_axi_wdata[1:0];
        host_mem_access_allow_ff <= s_axi_wdata[HOST_ALLOW_BIT];
      end
      if (wr_clock)
        fast_clock_select_ff <= s_axi_wdata[FAST_CLK_BIT];
    end
  end

  // ==========================================================================
  // AXI4-Lite handshakes
  // ==========================================================================
  // Address and data are taken together in one cycle; the answer follows
  // one clock later, which keeps the slave free of skid storage.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_rdata   <= 32'h0;
    end
    else
    begin
      s_axi_awready <= wr_go && !s_axi_awready;
      s_axi_wready  <= wr_go && !s_axi_awready;
      if (s_axi_awready)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      s_axi_arready <= s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // Flash arbitration
  // ==========================================================================
  // The host wins ties; a blocked host request never reaches the timer.
  // While a done pulse stands, its requester has not yet dropped the
  // request; a grant then would start the same access a second time.
  assign done_hold   = core_done_ff || host_done_ff;
  assign host_active = host_flash_req && host_mem_access_allow_ff; // R1
  assign grant_host  = !acc_busy && !done_hold && host_active;
  assign grant_core  = !acc_busy && !done_hold && !host_active
                    && core_flash_req;
  assign acc_req     = grant_host || grant_core;

  flash_wait_timer u_wait
  (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .acc_req    (acc_req),
    .wait_count (flash_wait_count_ff), // R4
    .acc_done   (acc_done),
    .acc_busy   (acc_busy)
  );

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      owner_host_ff <= 1'b0;
      core_done_ff  <= 1'b0;
      host_done_ff  <= 1'b0;
      blocked_ff    <= 1'b0;
    end
    else
    begin
      if (acc_req)
        owner_host_ff <= grant_host;
      core_done_ff <= acc_done && !owner_host_ff; // R4
      host_done_ff <= acc_done && owner_host_ff;
      blocked_ff   <= host_flash_req && !host_mem_access_allow_ff; // R1
    end
  end

  assign core_flash_done    = core_done_ff;
  assign host_flash_done    = host_done_ff;
  assign host_flash_blocked = blocked_ff;

  // ==========================================================================
  // Host wait limit and transceiver clock
  // ==========================================================================
  // The limit bounds the host WAIT strobe; on expiry WAIT drops even if the
  // Flash has not answered, since an overlong WAIT would hang the host bus.
  assign wait_limit = fast_clock_select_ff ? HOST_WAIT_FAST
                                           : HOST_WAIT_SLOW; // R8

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      host_wait_limit_counter_ff <= 8'h0;
      host_wait_ff               <= 1'b0;
      host_timeout_ff            <= 1'b0;
      div_ff                     <= 1'b0;
      attach_clk_en_ff           <= 1'b0;
    end
    else
    begin
      // The clear comes first so that an expiry in the same cycle wins.
      if (!host_flash_req)
        host_timeout_ff <= 1'b0;
      if (host_active && !host_wait_ff && !host_timeout_ff && !host_done_ff)
      begin
        host_wait_ff               <= 1'b1;
        host_wait_limit_counter_ff <= wait_limit;
      end
      else if (host_wait_ff)
      begin
        host_wait_limit_counter_ff <= host_wait_limit_counter_ff - 8'h1;
        if (host_done_ff)
          host_wait_ff <= 1'b0;
        else if (host_wait_limit_counter_ff == 8'h1)
        begin
          host_wait_ff    <= 1'b0; // R9
          host_timeout_ff <= 1'b1;
        end
      end
      div_ff           <= !div_ff;
      attach_clk_en_ff <= fast_clock_select_ff ? div_ff : 1'b1; // R7
    end
  end

  a_host_blocked: assert property (@(posedge aclk) disable iff (!aresetn) // R1
    (host_flash_req && !host_mem_access_allow_ff) |=> host_flash_blocked)
    else $error("blocked host request not flagged");
  a_flash_reset: assert property (@(posedge aclk) // R2
    !aresetn |=> flash_wait_count_ff == FLASH_WAIT_RST
               && fast_clock_select_ff)
    else $error("wrong reset value for wait count or clock select");
  a_attach_divide: assert property (@(posedge aclk) disable iff (!aresetn) // R7
    (fast_clock_select_ff && $past(fast_clock_select_ff) && attach_clk_en_ff)
      |=> !attach_clk_en_ff || !fast_clock_select_ff)
    else $error("transceiver enable not halved in fast mode");
  a_wait_bound: assert property (@(posedge aclk) disable iff (!aresetn) // R8
    host_wait_ff |-> host_wait_limit_counter_ff <= wait_limit)
    else $error("host wait count beyond limit");
  a_wait_slow: assert property (@(posedge aclk) disable iff (!aresetn) // R9
    ($rose(host_wait_ff) && !fast_clock_select_ff)
      |-> host_wait_limit_counter_ff == HOST_WAIT_SLOW)
    else $error("slow wait limit not loaded");
  a_core_done: assert property (@(posedge aclk) disable iff (!aresetn) // R4
    (acc_done && !owner_host_ff) |=> core_flash_done)
    else $error("core access completion lost");
  a_bresp_timing: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_awready |=> s_axi_bvalid)
    else $error("write response not given");
  a_fast_reset: assert property (@(posedge aclk) // R12
    !aresetn |=> fast_clock_select_ff == FAST_CLK_RST)
    else $error("fast clock select reset wrong");
endmodule : flash_wait_host_gate_clock_cfg
`default_nettype wire

// ---- dv/flash_req_model.sv ----
/*
  Requester model for one side of the Flash arbitration, core or host.
  Assumes requests are granted by logic on the same clock as the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module flash_req_model
(
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Bench control
  input  wire logic       go,
  input  wire logic       drop,
  // Access handshake
  input  wire logic       done,
  output logic            req_ff,
  output logic [7:0]      lat_ff
);
  // ==========
  // Request holding and latency count
  // ==========
  // The request stays up until the done pulse, as a real requester does.
  // A blocked host never sees done, so drop lets the bench withdraw it.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      req_ff <= 1'b0;
      lat_ff <= 8'h00;
    end
    else if (drop)
      req_ff <= 1'b0;
    else if (go)
    begin
      req_ff <= 1'b1;
      lat_ff <= 8'h00;
    end
    else if (req_ff && done)
      req_ff <= 1'b0;
    else if (req_ff)
      lat_ff <= lat_ff + 8'h01;
  end
endmodule : flash_req_model
`default_nettype wire

// ---- dv/tb.sv ----
/*
  Self-checking bench for the Flash wait and clock configuration block.
  Assumes dv/flash_req_model.sv models both Flash requesters.
*/
`timescale 1ns/1ps
`default_nettype none
module tb
  import flash_cfg_pkg::*;
;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [3:0]  awaddr = 4'h0;
  logic [3:0]  araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        go_c = 1'b0;
  logic        go_h = 1'b0;
  logic        drop_h = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        core_req, host_req, core_done, host_done;
  logic        blocked, hwait, attach_en, fast;
  logic [7:0]  lat_c, lat_h;
  logic [33:0] axi_q[$];
  logic [7:0]  lat_q[$];
  int          mismatches = 0;
  int          checks_done = 0;
  int          cycles = 0;
  int          seed = 32'hdc9d;
  int          rnd;
  logic [1:0]  code;

  initial forever #50 aclk = ~aclk;

  flash_wait_host_gate_clock_cfg dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .core_flash_req(core_req), .host_flash_req(host_req),
    .core_flash_done(core_done), .host_flash_done(host_done),
    .host_flash_blocked(blocked), .host_wait_ff(hwait),
    .attach_clk_en_ff(attach_en), .fast_clock_select_ff(fast));
  flash_req_model core_m (.aclk(aclk), .aresetn(aresetn), .go(go_c),
    .drop(1'b0), .done(core_done), .req_ff(core_req), .lat_ff(lat_c));
  flash_req_model host_m (.aclk(aclk), .aresetn(aresetn), .go(go_h),
    .drop(drop_h), .done(host_done), .req_ff(host_req), .lat_ff(lat_h));

  // ==========
  // Comparison and verdict
  // ==========
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude;
    if (mismatches == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  // ==========
  // Bus and access drivers
  // ==========
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                        input logic [1:0] r);
    axi_q.push_back({r, 32'h0});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    @(posedge aclk);
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, input logic [31:0] d,
                        input logic [1:0] r);
    axi_q.push_back({r, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    @(posedge aclk);
  endtask : axi_rd

  // The model counts from the grant edge to the edge that sees done: 2N+2.
  task automatic flash(input logic host, input logic [1:0] n);
    lat_q.push_back(8'(2 * int'(n) + 2));
    if (host) go_h <= 1'b1;
    else go_c <= 1'b1;
    @(posedge aclk);
    go_h <= 1'b0;
    go_c <= 1'b0;
    do @(posedge aclk);
    while ((host ? host_done : core_done) !== 1'b1);
    @(posedge aclk);
  endtask : flash

  task automatic attach_chk(input int exp);
    int ones;
    ones = 0;
    repeat (8)
    begin
      @(posedge aclk);
      if (attach_en === 1'b1) ones++;
    end
    check(34'(ones), 34'(exp));
  endtask : attach_chk

  // ==========
  // Result monitor
  // ==========
  always @(posedge aclk)
  begin
    if (bvalid === 1'b1 && bready) check({bresp, 32'h0}, axi_q.pop_front());
    if (rvalid === 1'b1 && rready)
      check({rresp, rresp === RESP_OKAY ? rdata : 32'h0},
            axi_q.pop_front());
    if (core_done === 1'b1) check(34'(lat_c), 34'(lat_q.pop_front()));
    if (host_done === 1'b1) check(34'(lat_h), 34'(lat_q.pop_front()));
    if (host_done === 1'b1) check({33'h0, hwait}, 34'h1);
    if (host_done === 1'b1) check({33'h0, blocked}, 34'h0);
  end

  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      conclude();
    end
  end

  // ==========
  // Main sequence
  // ==========
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check({33'h0, hwait}, 34'h0);
    axi_rd(OFS_FLASH_WAIT, 32'h0000000B, RESP_OKAY);
    axi_rd(OFS_CLOCK_CFG, 32'h00000080, RESP_OKAY);
    attach_chk(4);
    rnd = $random(seed);
    for (int i = 0; i < 4; i++)
    begin
      code = 2'(i + rnd);
      axi_wr(OFS_FLASH_WAIT, {28'h0, 4'h8 | {2'b00, code}}, RESP_OKAY);
      axi_rd(OFS_FLASH_WAIT, {28'h0, 4'h8 | {2'b00, code}}, RESP_OKAY);
      flash(1'b0, code);
      flash(1'b1, code);
    end
    // Reserved bits stay zero in every write.
    axi_wr(OFS_FLASH_WAIT, 32'h00000001, RESP_OKAY);
    go_h <= 1'b1;
    @(posedge aclk);
    go_h <= 1'b0;
    repeat (4) @(posedge aclk);
    check({33'h0, blocked}, 34'h1);
    drop_h <= 1'b1;
    @(posedge aclk);
    drop_h <= 1'b0;
    axi_wr(OFS_FLASH_WAIT, 32'h00000009, RESP_OKAY);
    flash(1'b1, 2'h1);
    axi_wr(OFS_CLOCK_CFG, 32'h00000000, RESP_OKAY);
    axi_rd(OFS_CLOCK_CFG, 32'h00000000, RESP_OKAY);
    check({33'h0, fast}, 34'h0);
    attach_chk(8);
    axi_wr(OFS_ACCESS_REQ, 32'h0, RESP_SLVERR);
    axi_rd(OFS_ACCESS_REQ, 32'h0, RESP_SLVERR);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(OFS_CLOCK_CFG, 32'h00000080, RESP_OKAY);
    axi_rd(OFS_FLASH_WAIT, 32'h0000000B, RESP_OKAY);
    axi_wr(OFS_CLOCK_CFG, 32'h00000080, RESP_OKAY);
    flash(1'b0, FLASH_WAIT_RST);
    conclude();
  end
endmodule : tb
`default_nettype wire
